//--- shared/ussr_pkg.sv
package ussr_pkg;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam int unsigned ADR_W = 10;
   localparam logic [7:0] IDX_IRQ_CTRL = 8'h0B;
   localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0C;
   localparam logic [7:0] IDX_RX_STATUS = 8'h18;
   localparam logic [7:0] IDX_RX_DATA = 8'h1A;
   localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8C;
   localparam logic [7:0] IDX_TX_STATUS = 8'h98;
   localparam logic [7:0] IDX_BAUD_DIV = 8'h99;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned BIT_PORT_EN = 7;
   localparam int unsigned BIT_NINE_RX = 6;
   localparam int unsigned BIT_SINGLE_RX = 5;
   localparam int unsigned BIT_CONT_RX = 4;
   localparam int unsigned BIT_OVERRUN = 1;
   localparam int unsigned BIT_NINTH_RX = 0;
   localparam int unsigned BIT_CLK_SRC = 7;
   localparam int unsigned BIT_CLOCKED = 4;
   localparam int unsigned BIT_TX_EMPTY = 1;
   localparam int unsigned BIT_GLOBAL_IE = 7;
   localparam int unsigned BIT_PERIPH_IE = 6;
   localparam int unsigned BIT_RX_IRQ = 5;

   // ---------------------------------------------------------------
   // Reset values, write masks, widths
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_TX_STATUS = 8'h02;
   localparam logic [7:0] WMASK_RX_STATUS = 8'hF8;
   localparam logic [7:0] WMASK_TX_STATUS = 8'hF5;
   localparam int unsigned WORD_W = 9;
   localparam logic [WORD_W-1:0] RST_WORD = 9'h000;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] LAST_BIT_8 = 4'h7;
   localparam logic [3:0] LAST_BIT_9 = 4'h8;
   localparam logic [12:0] VECTOR_ADDR = 13'h0004;

endpackage : ussr_pkg

//--- shared/ussr_hold_if.sv
`timescale 1ns/1ps
interface ussr_hold_if;
   logic wr;
   logic [ussr_pkg::WORD_W-1:0] wr_word;
   logic rd;
   logic full;
   logic [ussr_pkg::WORD_W-1:0] word;

   modport rx (output wr, output wr_word, output rd, input full, input word);
   modport hold (input wr, input wr_word, input rd, output full, output word);
endinterface : ussr_hold_if

//--- rtl/ussr_hold.sv
`timescale 1ns/1ps
// Receive data holding register: one word behind the shift register
module ussr_hold (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   ussr_hold_if.hold hb
);

   logic [ussr_pkg::WORD_W-1:0] word_q;
   logic full_q;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         word_q <= ussr_pkg::RST_WORD;
         full_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (hb.wr)
         begin
            word_q <= hb.wr_word;
            full_q <= 1'b1;
         end
         else if (hb.rd)
         begin
            full_q <= 1'b0;
         end
      end
   end

   assign hb.word = word_q;
   assign hb.full = full_q;

endmodule : ussr_hold

//--- rtl/ussr_rx_top.sv
`timescale 1ns/1ps
module ussr_rx_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ussr_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sck_i,
   input wire logic sdata_i,
   input wire logic sleep_i,
   output logic irq_o,
   output logic wake_o,
   output logic vector_o,
   output logic [12:0] vector_addr_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   ussr_hold_if hb ();

   logic [7:0] irq_ctrl_q;
   logic [7:0] pie_q;
   logic [7:0] rx_stat_q;
   logic [7:0] tx_stat_q;
   logic [7:0] baud_q;
   logic ovr_q;
   logic sck_m_q;
   logic sck_s_q;
   logic sck_p_q;
   logic dat_m_q;
   logic dat_s_q;
   logic [ussr_pkg::WORD_W-1:0] shift_q;
   logic [3:0] cnt_q;
   logic ack_q;
   logic [31:0] dat_o_q;
   logic irq_q;
   logic wake_q;
   logic vec_q;
   logic [12:0] vaddr_q;

   wire [7:0] reg_idx = wb_adr_i[ussr_pkg::ADR_W-1:2];
   wire bus_acc = wb_cyc_i & wb_stb_i & ~ack_q;
   wire wr_acc = bus_acc & wb_we_i & wb_sel_i[0];
   wire rd_acc = bus_acc & ~wb_we_i;

   function automatic logic hit(input logic [7:0] idx, input logic [7:0] cur);
      hit = (idx == cur);
   endfunction : hit

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   wire port_en = rx_stat_q[ussr_pkg::BIT_PORT_EN];
   wire nine_bit = rx_stat_q[ussr_pkg::BIT_NINE_RX];
   wire cont_rx = rx_stat_q[ussr_pkg::BIT_CONT_RX];
   wire single_rx = rx_stat_q[ussr_pkg::BIT_SINGLE_RX];
   wire clk_master = tx_stat_q[ussr_pkg::BIT_CLK_SRC];
   wire clocked = tx_stat_q[ussr_pkg::BIT_CLOCKED];
   // Single receive only counts when we own the clock; a slave ignores it
   wire rx_wanted = cont_rx | (clk_master & single_rx);
   // A master's clock stops in sleep; a slave keeps shifting on the far clock
   wire sleep_ok = ~sleep_i | ~clk_master;
   // Overrun stalls reception until continuous receive is cleared
   wire rx_en = port_en & clocked & rx_wanted & sleep_ok & ~ovr_q;

   // ---------------------------------------------------------------
   // Shift path
   // ---------------------------------------------------------------
   wire sck_fall = sck_p_q & ~sck_s_q;
   wire [3:0] last_cnt = nine_bit ? ussr_pkg::LAST_BIT_9 : ussr_pkg::LAST_BIT_8;
   wire [ussr_pkg::WORD_W-1:0] shift_nx = {dat_s_q, shift_q[ussr_pkg::WORD_W-1:1]};
   // In eight-bit mode the word sits in the upper bits of the shifter
   wire [ussr_pkg::WORD_W-1:0] word_nx = nine_bit ? shift_nx
                                       : {1'b0, shift_nx[ussr_pkg::WORD_W-1:1]};
   wire word_done = rx_en & sck_fall & (cnt_q == last_cnt);
   wire rd_data = rd_acc & hit(ussr_pkg::IDX_RX_DATA, reg_idx);
   // A read in the same cycle frees the holder, so the new word is not lost
   wire hold_busy = hb.full & ~rd_data;
   wire ovr_set = word_done & hold_busy;

   assign hb.wr = word_done & ~hold_busy;
   assign hb.wr_word = word_nx;
   assign hb.rd = rd_data;

   ussr_hold u_hold (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .hb(hb)
   );

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sck_m_q <= 1'b0;
         sck_s_q <= 1'b0;
         sck_p_q <= 1'b0;
         dat_m_q <= 1'b0;
         dat_s_q <= 1'b0;
      end
      else if (ce_i)
      begin
         sck_m_q <= sck_i;
         sck_s_q <= sck_m_q;
         sck_p_q <= sck_s_q;
         dat_m_q <= sdata_i;
         dat_s_q <= dat_m_q;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_q <= ussr_pkg::CNT_ZERO;
         shift_q <= ussr_pkg::RST_WORD;
      end
      else if (ce_i)
      begin
         // Dropping the enable throws away a partial word; a frozen core keeps it
         if (!rx_en)
         begin
            cnt_q <= ussr_pkg::CNT_ZERO;
            shift_q <= ussr_pkg::RST_WORD;
         end
         else if (sck_fall)
         begin
            shift_q <= shift_nx;
            cnt_q <= word_done ? ussr_pkg::CNT_ZERO : cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ovr_q <= 1'b0;
      else if (ce_i)
         ovr_q <= ovr_set | (ovr_q & cont_rx);
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   wire [7:0] flags_val = 8'(hb.full) << ussr_pkg::BIT_RX_IRQ;
   wire [7:0] rx_stat_val = (rx_stat_q & ussr_pkg::WMASK_RX_STATUS)
                          | (8'(ovr_q) << ussr_pkg::BIT_OVERRUN)
                          | (8'(hb.word[ussr_pkg::WORD_W-1]) << ussr_pkg::BIT_NINTH_RX);
   // No transmitter here, so the transmit shifter always reads empty
   wire [7:0] tx_stat_val = (tx_stat_q & ussr_pkg::WMASK_TX_STATUS)
                          | (8'(1'b1) << ussr_pkg::BIT_TX_EMPTY);
   wire [7:0] rd_byte =
      hit(ussr_pkg::IDX_IRQ_CTRL, reg_idx) ? irq_ctrl_q :
      hit(ussr_pkg::IDX_PERIPH_FLAGS, reg_idx) ? flags_val :
      hit(ussr_pkg::IDX_RX_STATUS, reg_idx) ? rx_stat_val :
      hit(ussr_pkg::IDX_RX_DATA, reg_idx) ? hb.word[7:0] :
      hit(ussr_pkg::IDX_PERIPH_ENABLES, reg_idx) ? pie_q :
      hit(ussr_pkg::IDX_TX_STATUS, reg_idx) ? tx_stat_val :
      hit(ussr_pkg::IDX_BAUD_DIV, reg_idx) ? baud_q : ussr_pkg::RST_BYTE;
   wire [7:0] wr_byte = wb_dat_i[7:0];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_ctrl_q <= ussr_pkg::RST_BYTE;
         pie_q <= ussr_pkg::RST_BYTE;
         rx_stat_q <= ussr_pkg::RST_BYTE;
         tx_stat_q <= ussr_pkg::RST_TX_STATUS;
         baud_q <= ussr_pkg::RST_BYTE;
      end
      else if (ce_i && wr_acc)
      begin
         if (hit(ussr_pkg::IDX_IRQ_CTRL, reg_idx))
            irq_ctrl_q <= wr_byte;
         if (hit(ussr_pkg::IDX_PERIPH_ENABLES, reg_idx))
            pie_q <= wr_byte;
         if (hit(ussr_pkg::IDX_RX_STATUS, reg_idx))
            rx_stat_q <= wr_byte & ussr_pkg::WMASK_RX_STATUS;
         if (hit(ussr_pkg::IDX_TX_STATUS, reg_idx))
            tx_stat_q <= wr_byte & ussr_pkg::WMASK_TX_STATUS;
         if (hit(ussr_pkg::IDX_BAUD_DIV, reg_idx))
            baud_q <= wr_byte;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         dat_o_q <= 32'h00000000;
      end
      else if (ce_i)
      begin
         ack_q <= bus_acc;
         if (rd_acc)
            dat_o_q <= {24'h000000, rd_byte};
      end
   end

   // ---------------------------------------------------------------
   // Interrupt, wake and vector outputs
   // ---------------------------------------------------------------
   wire irq_d = hb.full & pie_q[ussr_pkg::BIT_RX_IRQ];
   wire ints_on = irq_ctrl_q[ussr_pkg::BIT_GLOBAL_IE] & irq_ctrl_q[ussr_pkg::BIT_PERIPH_IE];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_q <= 1'b0;
         wake_q <= 1'b0;
         vec_q <= 1'b0;
         // Kept in a flop so that every output leaves a register
         vaddr_q <= ussr_pkg::VECTOR_ADDR;
      end
      else if (ce_i)
      begin
         irq_q <= irq_d;
         wake_q <= sleep_i & irq_d;
         vec_q <= irq_d & ints_on;
         vaddr_q <= ussr_pkg::VECTOR_ADDR;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_o_q;
   assign irq_o = irq_q;
   assign wake_o = wake_q;
   assign vector_o = vec_q;
   assign vector_addr_o = vaddr_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i || !ce_i);

   sequence s_bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   property p_bus_ack;
      s_bus_req |=> s_ack_pulse;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("ack not a single pulse");

   property p_load_word;
      (word_done && !hold_busy) |=> hb.full && hb.word == $past(word_nx);
   endproperty
   a_load_word: assert property (p_load_word) else $error("word not moved");

   property p_overrun;
      (word_done && hold_busy) |=> ovr_q && $stable(hb.word);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");

   property p_continuous_receive_enable_clear;
      (!cont_rx && !ovr_set) |=> !ovr_q;
   endproperty
   a_continuous_receive_enable_clear: assert property (p_continuous_receive_enable_clear) else $error("overrun kept");

   property p_idle_off;
      !rx_en |=> cnt_q == ussr_pkg::CNT_ZERO;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("shift while off");

   property p_word_len;
      word_done |-> cnt_q == (nine_bit ? ussr_pkg::LAST_BIT_9 : ussr_pkg::LAST_BIT_8);
   endproperty
   a_word_len: assert property (p_word_len) else $error("wrong word length");

   property p_irq_gate;
      hb.full ##1 hb.full |-> irq_o == $past(pie_q[ussr_pkg::BIT_RX_IRQ]);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq gating wrong");

   property p_wake;
      (sleep_i && hb.full && pie_q[ussr_pkg::BIT_RX_IRQ]) |=> wake_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");

   property p_vector;
      vector_o |-> irq_o && $past(ints_on) && vector_addr_o == ussr_pkg::VECTOR_ADDR;
   endproperty
   a_vector: assert property (p_vector) else $error("bad vector");

   property p_slave_en;
      (port_en && clocked && cont_rx && !clk_master && !ovr_q) |-> rx_en;
   endproperty
   a_slave_en: assert property (p_slave_en) else $error("slave receive blocked");

   property p_master_sleep;
      (clk_master && sleep_i) |=> cnt_q == ussr_pkg::CNT_ZERO;
   endproperty
   a_master_sleep: assert property (p_master_sleep) else $error("master shifts in sleep");

   property p_eight_top;
      (word_done && !hold_busy && !nine_bit) |=> !hb.word[ussr_pkg::WORD_W-1];
   endproperty
   a_eight_top: assert property (p_eight_top) else $error("ninth bit in eight-bit word");

   // A pop frees the holder unless a word lands in the same cycle
   property p_pop;
      rd_data |=> hb.full == $past(word_done);
   endproperty
   a_pop: assert property (p_pop) else $error("read did not pop");

endmodule : ussr_rx_top

//--- sim/ussr_link_master.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// External clocked master: drives shift clock and serial data
// ---------------------------------------------------------------
module ussr_link_master (
   output logic sck_o,
   output logic sdata_o
);
   initial
   begin
      sck_o = 1'b1;
      sdata_o = 1'b1;
   end

   // Clock stands high between frames; data settles half a period before each fall
   task automatic send(input logic [8:0] w, input int n);
      #37;
      for (int i = 0; i < n; i++)
      begin
         sdata_o = w[i];
         #400 sck_o = 1'b0;
         #400 sck_o = 1'b1;
      end
      // Released line shows the opposite level so a stale bit is never mistaken for data
      sdata_o = ~w[n-1];
   endtask : send
endmodule : ussr_link_master

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
   logic clk_i, rst_i, ce, cyc, stb, we, sleep, ack, irq, wake, vec, sck, sdata;
   logic [9:0] adr;
   logic [31:0] wdat, rdat;
   logic [12:0] vaddr;
   logic [7:0] lfsr_q = 8'h1F;
   logic [7:0] rxc = 8'h00;
   logic [8:0] held = 9'h000;
   int n_fail = 0;
   int n_compared = 0;
   int cont = 0, ie = 0, global_irq_enable = 0, peripheral_irq_enable = 0, full = 0, ovr = 0, mst = 0;
   logic [7:0] idx_t [8] = '{ussr_pkg::IDX_IRQ_CTRL, ussr_pkg::IDX_PERIPH_FLAGS,
      ussr_pkg::IDX_RX_STATUS, ussr_pkg::IDX_RX_DATA, ussr_pkg::IDX_PERIPH_ENABLES,
      ussr_pkg::IDX_TX_STATUS, ussr_pkg::IDX_BAUD_DIV, 8'h40};
   logic [7:0] rst_t [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};

   ussr_rx_top ussr_rx_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .sck_i(sck), .sdata_i(sdata), .sleep_i(sleep),
      .irq_o(irq), .wake_o(wake), .vector_o(vec), .vector_addr_o(vaddr));
   ussr_link_master ussr_link_master_i (.sck_o(sck), .sdata_o(sdata));

   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   // Entered right after a rising edge; holds the request until ack is sampled
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
      output logic [7:0] r);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat[7:0];
      if (n >= 50)
         chk("bus ack", 32'h0, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   task automatic rreg(input string nm, input logic [7:0] idx, input logic [31:0] exp);
      logic [7:0] r;
      bus(1'b0, idx, 8'h00, r);
      chk(nm, r, exp);
   endtask : rreg

   task automatic setrx(input logic [7:0] v);
      logic [7:0] r;
      rxc = v & 8'hF8;
      cont = v[4];
      if (cont == 0)
         ovr = 0;
      bus(1'b1, ussr_pkg::IDX_RX_STATUS, v, r);
   endtask : setrx

   task automatic outs();
      chk("irq", irq, full & ie);
      chk("wake", wake, sleep & full & ie);
      chk("vector", vec, full & ie & global_irq_enable & peripheral_irq_enable);
      rreg("flags", ussr_pkg::IDX_PERIPH_FLAGS, full << 5);
   endtask : outs

   // Model: word kept only while enabled; a second unread word is an overrun
   task automatic xfer(input int n);
      logic [8:0] w;
      int en;
      lfsr_q = lfsr(lfsr_q);
      w = {lfsr_q[3], lfsr_q};
      ussr_link_master_i.send(w, n);
      if (n == 8)
         w[8] = 1'b0;
      en = rxc[7] && (cont || (mst && rxc[5])) && !(mst && sleep) && !ovr;
      if (en && full)
         ovr = 1;
      else if (en)
      begin
         full = 1;
         held = w;
      end
      repeat (6) @(posedge clk_i);
      outs();
   endtask : xfer

   task automatic drain();
      rreg("status", ussr_pkg::IDX_RX_STATUS, rxc | (ovr << 1) | held[8]);
      rreg("data", ussr_pkg::IDX_RX_DATA, held[7:0]);
      full = 0;
      outs();
   endtask : drain

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      logic [7:0] r;
      rst_i = 1'b1;
      ce = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 10'h000;
      wdat = 32'h0;
      sleep = 1'b0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("vector addr", vaddr, 13'h0004);
      for (int i = 0; i < 8; i++)
         rreg("reset", idx_t[i], rst_t[i]);
      lfsr_q = lfsr(lfsr_q);
      bus(1'b1, ussr_pkg::IDX_BAUD_DIV, lfsr_q, r);
      rreg("baud", ussr_pkg::IDX_BAUD_DIV, lfsr_q);
      bus(1'b1, ussr_pkg::IDX_TX_STATUS, 8'h10, r); // clocked slave, far clock
      bus(1'b1, ussr_pkg::IDX_PERIPH_ENABLES, 8'h20, r);
      ie = 1;
      bus(1'b1, ussr_pkg::IDX_IRQ_CTRL, 8'hC0, r);
      global_irq_enable = 1;
      peripheral_irq_enable = 1;
      setrx(8'hB0); // single receive bit set, no effect
      xfer(8);
      drain();
      setrx(8'hD0);
      xfer(9);
      drain();
      xfer(9);
      xfer(9);
      drain();
      xfer(9); // stalled while overrun
      setrx(8'hE0); // single receive alone does nothing for a slave
      rreg("status", ussr_pkg::IDX_RX_STATUS, rxc | held[8]);
      xfer(8);
      setrx(8'h90);
      bus(1'b1, ussr_pkg::IDX_PERIPH_ENABLES, 8'h00, r);
      ie = 0;
      xfer(8);
      drain();
      bus(1'b1, ussr_pkg::IDX_PERIPH_ENABLES, 8'h20, r);
      ie = 1;
      sleep <= 1'b1;
      xfer(8);
      drain();
      sleep <= 1'b0;
      bus(1'b1, ussr_pkg::IDX_IRQ_CTRL, 8'h80, r);
      peripheral_irq_enable = 0;
      xfer(8);
      drain();
      ce <= 1'b0;
      ussr_link_master_i.send(9'h0A5, 8);
      @(posedge clk_i);
      ce <= 1'b1;
      outs(); // frozen core takes no word
      bus(1'b1, ussr_pkg::IDX_TX_STATUS, 8'h90, r);
      mst = 1;
      setrx(8'hA0);
      xfer(8); // single receive serves a clock master
      sleep <= 1'b1;
      xfer(8); // master clock stops in sleep
      sleep <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      full = 0;
      ie = 0;
      global_irq_enable = 0;
      peripheral_irq_enable = 0;
      mst = 0;
      for (int i = 0; i < 8; i++)
         rreg("reset again", idx_t[i], rst_t[i]);
      outs();
      tally_and_finish();
   end

   initial
   begin
      #2000000;
      n_fail++;
      tally_and_finish();
   end
endmodule : tb
